//--- rtl/pcr_pkg.sv
// What this block does
// - Open-drain select: 0 enables open-drain
// - Pull-high select: 0 enables pull-high
// - Watchdog enable bit 7, read/write
// - Bit 6 makes port5 pin0 external interrupt
// - Select low blocks external interrupt path
// - Bit 5 enables watchdog prescaler
// - Prescale ratio two to field plus one
// - Unimplemented bits read as zero
// - Interrupt mask, one enable per source
// - Global gate opened/closed by instructions
// - Ten-bit PWM period, upper bits shared
// - PWM high from period start until duty
// - Ten-bit duty, upper bits shared register
// - PWM timer count read-only
// - Eight-bit counter, internal or external source
// - Counter write clears counter prescaler
// - Watchdog clear or sleep clears watchdog
// - Internal counter halts in sleep, ADC exception
// - Watchdog runs in sleep, time-out resets
// - Unscaled watchdog time-out about 18 ms
// - Direction bit 0 output, 1 input
// - Edge select 1 counts falling edge
package pcr_pkg;
   localparam logic [11:0] OFF_OPEN_DRAIN  = 12'h000;
   localparam logic [11:0] OFF_PULL_HIGH   = 12'h004;
   localparam logic [11:0] OFF_WDOG_CTRL   = 12'h008;
   localparam logic [11:0] OFF_IRQ_MASK    = 12'h00C;
   localparam logic [11:0] OFF_PRD_A       = 12'h010;
   localparam logic [11:0] OFF_PRD_B       = 12'h014;
   localparam logic [11:0] OFF_PRD_C       = 12'h018;
   localparam logic [11:0] OFF_DUTY_A      = 12'h01C;
   localparam logic [11:0] OFF_DUTY_B      = 12'h020;
   localparam logic [11:0] OFF_DUTY_C      = 12'h024;
   localparam logic [11:0] OFF_DUTY_HIGH   = 12'h028;
   localparam logic [11:0] OFF_CNT_A       = 12'h02C;
   localparam logic [11:0] OFF_CNT_B       = 12'h030;
   localparam logic [11:0] OFF_CNT_C       = 12'h034;
   localparam logic [11:0] OFF_CNT_HIGH    = 12'h038;
   localparam logic [11:0] OFF_PRD_HIGH    = 12'h03C;
   localparam logic [11:0] OFF_CNT_CTRL    = 12'h040;
   localparam logic [11:0] OFF_TIMER       = 12'h044;
   localparam logic [11:0] OFF_DIR5        = 12'h048;
   localparam logic [11:0] OFF_SYS_CTRL    = 12'h04C;
   localparam logic [7:0] RST_OPEN_DRAIN = 8'hFF;
   localparam logic [7:0] RST_PULL_HIGH  = 8'hFF;
   localparam logic [7:0] RST_WDOG_CTRL  = 8'h80;
   localparam logic [7:0] RST_IRQ_MASK   = 8'h00;
   localparam logic [7:0] RST_CNT_CTRL   = 8'hBF;
   localparam logic [7:0] RST_DIR5       = 8'hFF;
   localparam logic [7:0] WDOG_CTRL_MASK = 8'hFC;
   localparam logic [7:0] HIGH_MASK      = 8'h3F;
   localparam int WDOG_BIT_EN  = 7;
   localparam int WDOG_BIT_EIS = 6;
   localparam int WDOG_BIT_PSE = 5;
   localparam int CNT_BIT_SRC  = 5;
   localparam int CNT_BIT_EDGE = 4;
   localparam int CNT_BIT_PSE  = 3;
   localparam int WDOG_TIMEOUT_MS = 18;
   localparam int CLOCK_KHZ = 50000;
   localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * CLOCK_KHZ;
   typedef struct packed {
      logic wdog_clear;
      logic sleep_enter;
      logic irq_on;
      logic irq_off;
   } pcr_instr_t;
   typedef struct packed {
      logic comparator;
      logic pwm_c;
      logic pwm_b;
      logic pwm_a;
      logic adc_done;
      logic ext_pin;
      logic port_change;
      logic counter_overflow;
   } pcr_irq_t;
endpackage

//--- rtl/pcr_regs.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs
   import pcr_pkg::*;
#(
   parameter int WDOG_TIMEOUT = WDOG_TIMEOUT_CYC
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire pcr_instr_t  instr,
   input  wire logic        adc_busy,
   input  wire logic        adc_wake_enable,
   input  wire logic        counter_pin,
   input  wire logic        ext_irq_pin,
   input  wire pcr_irq_t    irq_flags,
   output logic             irq_request,
   output logic             ext_irq_event,
   output logic [7:0]       port5_open_drain_en,
   output logic [7:0]       pull_high_en,
   output logic [7:0]       port5_dir_output,
   output logic [2:0]       pwm_out,
   output logic             watchdog_reset,
   output logic             counter_overflow
);
   logic [7:0]  open_drain_select;
   logic [7:0]  pull_high_select;
   logic [7:0]  watchdog_control;
   logic [7:0]  interrupt_mask;
   logic [7:0]  period_low [3];
   logic [7:0]  duty_low [3];
   logic [7:0]  pwm_duty_upper_bits;
   logic [7:0]  period_upper_bits;
   logic [9:0]  pwm_timer [3];
   logic [7:0]  counter_control_reg;
   logic [7:0]  counter;
   logic [7:0]  counter_prescale;
   logic [7:0]  port_direction;
   logic        irq_gate;
   logic        sleeping;
   logic [7:0]  wdog_prescale;
   logic [31:0] wdog_count;
   logic [2:0]  cpin_sync;
   logic [1:0]  xpin_sync;
   logic        xpin_last;

   wire wr = psel & penable & pwrite;
   wire [7:0] wd = pwdata[7:0];

   // Low ones, as many as the ratio's exponent: code 0 divides by two
   function automatic logic [7:0] ratio_mask(input logic [2:0] code);
      ratio_mask = 8'((9'h001 << (9'(code) + 9'h001)) - 9'h001);
   endfunction

   function automatic logic [9:0] upper(input logic [7:0] hi,
                                        input logic [7:0] lo,
                                        input int         ch);
      upper = {hi[2*ch+1], hi[2*ch], lo};
   endfunction

   // APB always ready, unmapped reads zero with error
   assign pready = 1'b1;
   wire hit = (paddr[1:0] == 2'b00) && (paddr <= OFF_SYS_CTRL);
   assign pslverr = psel & penable & ~hit;

   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         open_drain_select   <= RST_OPEN_DRAIN;
         pull_high_select    <= RST_PULL_HIGH;
         watchdog_control    <= RST_WDOG_CTRL;
         interrupt_mask      <= RST_IRQ_MASK;
         period_low          <= '{default: 8'h00};
         duty_low            <= '{default: 8'h00};
         pwm_duty_upper_bits <= 8'h00;
         period_upper_bits   <= 8'h00;
         counter_control_reg <= RST_CNT_CTRL;
         port_direction      <= RST_DIR5;
         irq_gate            <= 1'b0;
      end
      else
      begin
         if (wr && paddr == OFF_OPEN_DRAIN)
            open_drain_select <= wd;
         if (wr && paddr == OFF_PULL_HIGH)
            pull_high_select <= wd;
         if (wr && paddr == OFF_WDOG_CTRL)
            watchdog_control <= wd & WDOG_CTRL_MASK;
         if (wr && paddr == OFF_IRQ_MASK)
            interrupt_mask <= wd;
         if (wr && paddr == OFF_PRD_A)
            period_low[0] <= wd;
         if (wr && paddr == OFF_PRD_B)
            period_low[1] <= wd;
         if (wr && paddr == OFF_PRD_C)
            period_low[2] <= wd;
         if (wr && paddr == OFF_DUTY_A)
            duty_low[0] <= wd;
         if (wr && paddr == OFF_DUTY_B)
            duty_low[1] <= wd;
         if (wr && paddr == OFF_DUTY_C)
            duty_low[2] <= wd;
         if (wr && paddr == OFF_DUTY_HIGH)
            pwm_duty_upper_bits <= wd & HIGH_MASK;
         if (wr && paddr == OFF_PRD_HIGH)
            period_upper_bits <= wd & HIGH_MASK;
         if (wr && paddr == OFF_CNT_CTRL)
            counter_control_reg <= wd;
         if (wr && paddr == OFF_DIR5)
            port_direction <= wd;
         if (instr.irq_on)
            irq_gate <= 1'b1;
         else if (instr.irq_off)
            irq_gate <= 1'b0;
      end

   // Sleep ends only by reset or a wake source outside
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         sleeping <= 1'b0;
      else if (instr.sleep_enter)
         sleeping <= 1'b1;
      else if (|(irq_flags & interrupt_mask))
         sleeping <= 1'b0;

   assign port5_open_drain_en = ~open_drain_select;
   assign pull_high_en        = ~pull_high_select;
   assign port5_dir_output    = ~port_direction;

   assign irq_request = irq_gate & |(irq_flags & interrupt_mask);

   // Both pins come from outside; two stages before use
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         cpin_sync <= 3'b000;
         xpin_sync <= 2'b11;
         xpin_last <= 1'b1;
      end
      else
      begin
         cpin_sync <= {cpin_sync[1:0], counter_pin};
         xpin_sync <= {xpin_sync[0], ext_irq_pin};
         xpin_last <= xpin_sync[1];
      end

   assign ext_irq_event = watchdog_control[WDOG_BIT_EIS]
                          & xpin_last & ~xpin_sync[1];

   wire ext_src  = counter_control_reg[CNT_BIT_SRC];
   wire fall     = counter_control_reg[CNT_BIT_EDGE];
   wire pin_edge = fall ? (cpin_sync[2] & ~cpin_sync[1])
                        : (~cpin_sync[2] & cpin_sync[1]);
   // internal source halts in sleep unless ADC wake
   wire run_int  = ~sleeping | (adc_busy & adc_wake_enable);
   wire tick_in  = ext_src ? pin_edge : run_int;
   wire cnt_pse  = counter_control_reg[CNT_BIT_PSE];
   wire [7:0] cmask = ratio_mask(counter_control_reg[2:0]);
   wire cnt_step = tick_in
                   & (~cnt_pse | ((counter_prescale & cmask) == cmask));
   wire cnt_wr   = wr && paddr == OFF_TIMER;
   assign counter_overflow = cnt_step & (counter == 8'hFF) & ~cnt_wr;

   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         counter          <= 8'h00;
         counter_prescale <= 8'h00;
      end
      else if (cnt_wr)
      begin
         counter          <= wd;
         counter_prescale <= 8'h00;
      end
      else if (tick_in)
      begin
         counter_prescale <= counter_prescale + 8'h01;
         if (cnt_step)
            counter <= counter + 8'h01;
      end

   wire [7:0] wmask = ratio_mask(watchdog_control[4:2]);
   wire wdog_pse  = watchdog_control[WDOG_BIT_PSE];
   wire wdog_step = ~wdog_pse | ((wdog_prescale & wmask) == wmask);
   wire wdog_on   = watchdog_control[WDOG_BIT_EN];
   wire wdog_clr  = instr.wdog_clear | instr.sleep_enter;
   assign watchdog_reset = wdog_on & wdog_step
                           & (wdog_count == 32'(WDOG_TIMEOUT - 1))
                           & ~wdog_clr;

   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         wdog_prescale <= 8'h00;
         wdog_count    <= 32'h0000_0000;
      end
      else if (wdog_clr || !wdog_on || watchdog_reset)
      begin
         wdog_prescale <= 8'h00;
         wdog_count    <= 32'h0000_0000;
      end
      else
      begin
         wdog_prescale <= wdog_prescale + 8'h01;
         if (wdog_step)
            wdog_count <= wdog_count + 32'h0000_0001;
      end

   wire [9:0] prd  [3];
   wire [9:0] duty [3];
   genvar g;
   for (g = 0; g < 3; g++)
   begin : ch
      assign prd[g]  = upper(period_upper_bits, period_low[g], g);
      assign duty[g] = upper(pwm_duty_upper_bits, duty_low[g], g);
   end

   // low once timer reaches duty; one process, halted in sleep
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         pwm_timer <= '{default: 10'h000};
         pwm_out   <= 3'b000;
      end
      else if (!sleeping)
         for (int i = 0; i < 3; i++)
            if (pwm_timer[i] >= prd[i])
            begin
               pwm_timer[i] <= 10'h000;
               pwm_out[i]   <= (duty[i] != 10'h000);
            end
            else
            begin
               pwm_timer[i] <= pwm_timer[i] + 10'h001;
               if (pwm_timer[i] + 10'h001 == duty[i])
                  pwm_out[i] <= 1'b0;
            end

   wire [7:0] cnt_high = {2'b00, pwm_timer[2][9:8],
                          pwm_timer[1][9:8], pwm_timer[0][9:8]};
   logic [7:0] rsel;
   always_comb
   begin
      rsel = 8'h00;
      unique case (paddr)
         OFF_OPEN_DRAIN: rsel = open_drain_select;
         OFF_PULL_HIGH:  rsel = pull_high_select;
         OFF_WDOG_CTRL:  rsel = watchdog_control;
         OFF_IRQ_MASK:   rsel = interrupt_mask;
         OFF_PRD_A:      rsel = period_low[0];
         OFF_PRD_B:      rsel = period_low[1];
         OFF_PRD_C:      rsel = period_low[2];
         OFF_DUTY_A:     rsel = duty_low[0];
         OFF_DUTY_B:     rsel = duty_low[1];
         OFF_DUTY_C:     rsel = duty_low[2];
         OFF_DUTY_HIGH:  rsel = pwm_duty_upper_bits;
         OFF_CNT_A:      rsel = pwm_timer[0][7:0];
         OFF_CNT_B:      rsel = pwm_timer[1][7:0];
         OFF_CNT_C:      rsel = pwm_timer[2][7:0];
         OFF_CNT_HIGH:   rsel = cnt_high;
         OFF_PRD_HIGH:   rsel = period_upper_bits;
         OFF_CNT_CTRL:   rsel = counter_control_reg;
         OFF_TIMER:      rsel = counter;
         OFF_DIR5:       rsel = port_direction;
         OFF_SYS_CTRL:   rsel = {6'h00, sleeping, irq_gate};
         default:        rsel = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h00_0000, rsel};
endmodule
`default_nettype wire

//--- tb/pcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_asserts
   import pcr_pkg::*;
#(
   parameter int WDOG_TIMEOUT = 50
)
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire pcr_instr_t  instr,
   input wire pcr_irq_t    irq_flags,
   input wire logic        irq_request,
   input wire logic        ext_irq_event,
   input wire logic [7:0]  port5_open_drain_en,
   input wire logic [7:0]  pull_high_en,
   input wire logic        watchdog_reset
);
   wire  wr = psel & penable & pwrite;
   logic sel_ext;
   logic wd_on;
   // Shadow bits, the bank itself is hidden
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         sel_ext <= 1'b0;
         wd_on   <= 1'b1;
      end
      else if (wr && paddr == OFF_WDOG_CTRL)
      begin
         sel_ext <= pwdata[WDOG_BIT_EIS];
         wd_on   <= pwdata[WDOG_BIT_EN];
      end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_od_follow: assert property (wr && paddr == OFF_OPEN_DRAIN
      |=> port5_open_drain_en == ~$past(pwdata[7:0]))
      else $error("open-drain enables wrong");
   a_ph_follow: assert property (wr && paddr == OFF_PULL_HIGH
      |=> pull_high_en == ~$past(pwdata[7:0]))
      else $error("pull-high enables wrong");
   a_unmapped_err: assert property (psel && penable
      && paddr > OFF_SYS_CTRL |-> pslverr)
      else $error("no error on unmapped access");
   a_high_zero: assert property (psel && !penable && !pwrite
      && (paddr == OFF_CNT_HIGH || paddr == OFF_DUTY_HIGH)
      |=> prdata[31:6] == '0)
      else $error("unused bits read nonzero");
   a_irq_cause: assert property (irq_request |-> irq_flags != '0)
      else $error("interrupt without source");
   a_gate_off: assert property (instr.irq_off && !instr.irq_on
      |=> !irq_request)
      else $error("interrupt after gate closed");
   a_ext_block: assert property (!sel_ext |-> !ext_irq_event)
      else $error("external event while unselected");
   a_wdog_off: assert property (!wd_on |-> !watchdog_reset)
      else $error("time-out while disabled");
   a_wdog_clr: assert property (instr.wdog_clear
      |=> !watchdog_reset [*8])
      else $error("time-out right after clear");
endmodule
bind pcr_regs pcr_regs_asserts #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) chk (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .instr(instr), .irq_flags(irq_flags),
   .irq_request(irq_request), .ext_irq_event(ext_irq_event),
   .port5_open_drain_en(port5_open_drain_en),
   .pull_high_en(pull_high_en), .watchdog_reset(watchdog_reset));
`default_nettype wire

//--- tb/pcr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pcr_regs_bench
   import pcr_pkg::*;
;
   localparam int WT = 50;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, d;
   logic [31:0] seed = 32'h22A33ECF;
   logic        pready, pslverr, err, irq_request, ext_irq_event;
   logic        watchdog_reset, counter_overflow;
   logic        adc_busy = 1'b0, adc_wake = 1'b0;
   logic        counter_pin = 1'b0, ext_irq_pin = 1'b1;
   logic [7:0]  odn, phn, dirn;
   logic [7:0]  model [0:19];
   logic [2:0]  pwm_out;
   pcr_instr_t  instr = '0;
   pcr_irq_t    irq_flags = '0;
   int          n_errors = 0, compares = 0, cnt, f;
   always #10 clock = ~clock;
   pcr_regs #(.WDOG_TIMEOUT(WT)) uut (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr(instr),
      .adc_busy(adc_busy), .adc_wake_enable(adc_wake),
      .counter_pin(counter_pin), .ext_irq_pin(ext_irq_pin),
      .irq_flags(irq_flags), .irq_request(irq_request),
      .ext_irq_event(ext_irq_event), .port5_open_drain_en(odn),
      .pull_high_en(phn), .port5_dir_output(dirn), .pwm_out(pwm_out),
      .watchdog_reset(watchdog_reset),
      .counter_overflow(counter_overflow));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Writable bits of each word, by index
   function automatic logic [7:0] wmask(input int i);
      case (i)
         2: return WDOG_CTRL_MASK;
         10, 15: return HIGH_MASK;
         11, 12, 13, 14, 19: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction
   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      foreach (model[i]) model[i] = 8'h00;
      model[0] = RST_OPEN_DRAIN;
      model[1] = RST_PULL_HIGH;
      model[2] = RST_WDOG_CTRL;
      model[16] = RST_CNT_CTRL;
      model[18] = RST_DIR5;
   endtask
   // Idle edge first, so no signal is driven twice in one step
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] dat);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse_gate(input logic on);
      instr.irq_on <= on;
      instr.irq_off <= !on;
      @(posedge clock);
      instr <= '0;
   endtask
   initial
   begin
      do_reset();
      for (int n = 0; n < 3; n++)
         foreach (model[i])
            if (i < 11 || i == 15 || i > 17)
            begin
               if (n > 0)
               begin
                  seed = xs(seed);
                  // Watchdog kept off so time-outs stay out of the way
                  d = (i == 2) ? seed & 32'h7F : seed;
                  apb(12'(i * 4), 1'b1, d);
                  model[i] = (model[i] & ~wmask(i)) | (d[7:0] & wmask(i));
               end
               apb(12'(i * 4), 1'b0, 32'h0);
               `CHK({err, rd}, {1'b0, 24'h0, model[i]})
            end
      `CHK(odn, ~model[0])
      `CHK(phn, ~model[1])
      `CHK(dirn, ~model[18])
      apb(12'h100, 1'b1, 32'h0);
      `CHK(err, 1'b1)
      pulse_gate(1'b1);
      for (int i = 0; i < 8; i++)
      begin
         apb(OFF_IRQ_MASK, 1'b1, 32'h1 << i);
         irq_flags <= pcr_irq_t'(~(8'h01 << i));
         @(negedge clock);
         `CHK(irq_request, 1'b0)
         @(posedge clock);
         irq_flags <= pcr_irq_t'(8'h01 << i);
         @(negedge clock);
         `CHK(irq_request, 1'b1)
         @(posedge clock);
      end
      pulse_gate(1'b0);
      @(negedge clock);
      `CHK(irq_request, 1'b0)
      @(posedge clock);
      irq_flags <= '0;
      for (int j = 0; j < 3; j++)
      begin
         f = (j == 0) ? 1 : 2 << (j - 1);
         apb(OFF_WDOG_CTRL, 1'b1, j == 0 ? 32'h80 : 32'hA0 | (j - 1) << 2);
         instr.wdog_clear <= 1'b1;
         @(posedge clock);
         instr.wdog_clear <= 1'b0;
         cnt = 0;
         while (watchdog_reset !== 1'b1 && cnt < 1000)
         begin
            @(negedge clock);
            cnt++;
         end
         `CHK(cnt >= WT * f - f - 2 && cnt <= WT * f + f + 2, 1'b1)
         do_reset();
         apb(OFF_WDOG_CTRL, 1'b1, 32'h0);
      end
      for (int ch = 0; ch < 3; ch++)
      begin
         apb(12'(OFF_PRD_A + 4 * ch), 1'b1, 32'(8 + ch));
         apb(12'(OFF_DUTY_A + 4 * ch), 1'b1, 32'(3 + ch));
      end
      for (int h = 0; h < 2; h++)
      begin
         // Bit 8 of every duty set: no match, output stays high
         apb(OFF_DUTY_HIGH, 1'b1, 32'(h * 8'h15));
         repeat (12) @(posedge clock);
         for (int ch = 0; ch < 3; ch++)
         begin
            cnt = 0;
            repeat (3 * (9 + ch))
            begin
               @(negedge clock);
               cnt += (pwm_out[ch] === 1'b1);
            end
            `CHK(cnt, h ? 3 * (9 + ch) : 3 * (3 + ch))
         end
      end
      apb(OFF_CNT_A, 1'b1, 32'hFF);
      apb(OFF_CNT_A, 1'b0, 32'h0);
      `CHK(rd <= 32'h8, 1'b1)
      apb(OFF_CNT_CTRL, 1'b1, 32'h30);
      apb(OFF_TIMER, 1'b1, 32'h0);
      repeat (5)
      begin
         counter_pin <= 1'b1;
         repeat (4) @(posedge clock);
         counter_pin <= 1'b0;
         repeat (4) @(posedge clock);
      end
      apb(OFF_TIMER, 1'b0, 32'h0);
      `CHK(rd, 32'h5)
      // counter prescaler, code 1 divides by four
      apb(OFF_CNT_CTRL, 1'b1, 32'h09);
      apb(OFF_TIMER, 1'b1, 32'h0);
      repeat (40) @(posedge clock);
      apb(OFF_TIMER, 1'b0, 32'h0);
      `CHK(rd, 32'hA)
      for (int e = 0; e < 2; e++)
      begin
         apb(OFF_WDOG_CTRL, 1'b1, 32'(e) << 6);
         ext_irq_pin <= 1'b0;
         cnt = 0;
         repeat (6)
         begin
            @(negedge clock);
            cnt += (ext_irq_event === 1'b1);
         end
         `CHK(cnt, e)
         @(posedge clock);
         ext_irq_pin <= 1'b1;
         repeat (4) @(posedge clock);
      end
      apb(OFF_CNT_CTRL, 1'b1, 32'h0);
      apb(OFF_TIMER, 1'b1, 32'hF0);
      cnt = 0;
      while (counter_overflow !== 1'b1 && cnt < 100)
      begin
         @(negedge clock);
         cnt++;
      end
      `CHK(cnt >= 13 && cnt <= 19, 1'b1)
      @(posedge clock);
      instr.sleep_enter <= 1'b1;
      @(posedge clock);
      instr.sleep_enter <= 1'b0;
      apb(OFF_TIMER, 1'b0, 32'h0);
      d = rd;
      repeat (10) @(posedge clock);
      apb(OFF_TIMER, 1'b0, 32'h0);
      `CHK(rd, d)
      report_and_stop();
   end
   initial
   begin
      #1000000;
      n_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
